/* File: common/xldm_pkg.sv */
// Shared constants and types for the lane deskew and gap manager
package xldm_pkg;

  // ----------------------------------------------------------------
  // Lane and column layout
  // ----------------------------------------------------------------
  localparam int NUM_LANES  = 4;
  localparam int FIFO_DEPTH = 11;
  localparam int ADDR_W     = 8;

  typedef struct packed {
    logic       err;
    logic       ctrl;
    logic [7:0] data;
  } xldm_lane_s;

  typedef xldm_lane_s [NUM_LANES-1:0] xldm_column_t;

  // ----------------------------------------------------------------
  // Character codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_ALIGN  = 8'h7C;
  localparam logic [7:0] CODE_SYNC   = 8'hBC;
  localparam logic [7:0] CODE_SKIP   = 8'h1C;
  localparam logic [7:0] CODE_IDLE   = 8'h07;
  localparam logic [7:0] CODE_TERM   = 8'hFD;
  localparam logic [7:0] CODE_SEQ    = 8'h9C;
  localparam logic [7:0] FAULT_ZERO  = 8'h00;
  localparam logic [7:0] FAULT_LOCAL = 8'h01;
  localparam logic [7:0] FAULT_REM   = 8'h02;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_REALIGN = 8'h08;

  localparam int CTRL_INDEP_BIT  = 0;
  localparam int CTRL_XGXS_BIT   = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int STAT_ALIGN_BIT  = 12;
  localparam int REALIGN_BIT     = 4;

  // ----------------------------------------------------------------
  // Gap generation and state machine encodings
  // ----------------------------------------------------------------
  localparam logic [4:0]  SPACING_RESET = 5'h10;
  localparam logic [15:0] LFSR_SEED     = 16'hACE1;

  typedef enum logic [2:0] {
    column_search_state,
    column_confirm_one,
    column_confirm_two,
    column_confirm_three,
    column_aligned,
    column_miss_one,
    column_miss_two,
    column_miss_three
  } xldm_col_e;

  typedef enum logic {
    gap_send_data,
    gap_send_fill
  } xldm_gap_e;

endpackage : xldm_pkg

/* File: logic/xldm_lane_deskew.sv */
// Receive lane deskew, column alignment and transmit gap management
`timescale 1ns/1ns
`default_nettype none


module xldm_lane_deskew #(
  parameter int FIFO_DEPTH = xldm_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Register port
  input  wire logic [xldm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  // Receive lanes from the deserializers
  input  wire logic [3:0]                   rx_lane_clk,
  input  wire xldm_pkg::xldm_column_t       rx_lane_in,
  input  wire logic [3:0]                   lane_locked,
  // Receive parallel output
  output xldm_pkg::xldm_column_t            rx_col,
  output logic      [3:0]                   rx_col_valid,
  // Transmit parallel input
  input  wire logic                         tx_lane_a_clock,
  input  wire xldm_pkg::xldm_column_t       tx_lane_data,
  // Transmit lanes to the serializers
  output xldm_pkg::xldm_column_t            tx_col,
  output logic                              tx_col_valid
);

  localparam int PW = $clog2(FIFO_DEPTH);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16)
      $error("FIFO_DEPTH must be 2 to 16");
  end

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0]            lclk_m, lclk_s, lclk_d;
  logic [3:0]            lock_m, lock_s;
  xldm_pkg::xldm_column_t rxd_m, rxd_s;
  logic                  tclk_m, tclk_s, tclk_d;
  xldm_pkg::xldm_column_t txd_m, txd_s;
  logic [3:0]            lane_edge;
  logic                  rx_lane_a_clock;
  logic                  tx_edge;

  always_ff @(posedge clk) begin
    if (rst)
    begin
      lclk_m <= 4'h0;
      lclk_s <= 4'h0;
      lclk_d <= 4'h0;
      lock_m <= 4'h0;
      lock_s <= 4'h0;
      rxd_m  <= '0;
      rxd_s  <= '0;
      tclk_m <= 1'b0;
      tclk_s <= 1'b0;
      tclk_d <= 1'b0;
      txd_m  <= '0;
      txd_s  <= '0;
    end
    else
    begin
      lclk_m <= rx_lane_clk;
      lclk_s <= lclk_m;
      lclk_d <= lclk_s;
      lock_m <= lane_locked;
      lock_s <= lock_m;
      rxd_m  <= rx_lane_in;
      rxd_s  <= rxd_m;
      tclk_m <= tx_lane_a_clock;
      tclk_s <= tclk_m;
      tclk_d <= tclk_s;
      txd_m  <= tx_lane_data;
      txd_s  <= txd_m;
    end
  end

  assign lane_edge       = lclk_s & ~lclk_d;
  assign rx_lane_a_clock = lane_edge[0];
  assign tx_edge         = tclk_s & ~tclk_d;

  // ----------------------------------------------------------------
  // Control register and mode bits
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  logic       indep_mode;
  logic       xgxs_en;

  always_ff @(posedge clk) begin
    if (rst)
      ctrl <= xldm_pkg::CTRL_RESET;
    else if (reg_wr && reg_addr == xldm_pkg::REG_CTRL)
      ctrl <= reg_wdata[1:0];
  end

  assign indep_mode = ctrl[xldm_pkg::CTRL_INDEP_BIT];
  assign xgxs_en    = ctrl[xldm_pkg::CTRL_XGXS_BIT];

  // ----------------------------------------------------------------
  // Per-lane receive FIFOs
  // ----------------------------------------------------------------
  xldm_pkg::xldm_col_e    col_state;
  xldm_pkg::xldm_column_t rd_word;
  logic [3:0]             a_seen;
  logic                   realign;
  logic                   rd_step;

  assign realign = (col_state == xldm_pkg::column_search_state)
                   && (&a_seen) && (&lock_s) && !indep_mode;
  assign rd_step = rx_lane_a_clock && !realign && !indep_mode;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : wrap_inc

  genvar gi;
  generate
    for (gi = 0; gi < xldm_pkg::NUM_LANES; gi++)
    begin : g_lane
      xldm_pkg::xldm_lane_s mem [FIFO_DEPTH];
      logic [PW-1:0]        wr_ptr;
      logic [PW-1:0]        rd_ptr;
      logic [PW-1:0]        a_pos;
      logic                 is_a;

      assign is_a = rxd_s[gi].ctrl
                    && rxd_s[gi].data == xldm_pkg::CODE_ALIGN;

      // Storage written on the lane's own recovered clock edge
      always_ff @(posedge clk) begin
        if (lane_edge[gi] && !indep_mode)
          mem[wr_ptr] <= rxd_s[gi];
      end

      always_ff @(posedge clk) begin
        if (rst)
        begin
          wr_ptr    <= '0;
          a_pos     <= '0;
          a_seen[gi] <= 1'b0;
        end
        else
        begin
          if (lane_edge[gi] && !indep_mode)
            wr_ptr <= wrap_inc(wr_ptr);
          if (realign || col_state != xldm_pkg::column_search_state)
            a_seen[gi] <= 1'b0;
          else if (lane_edge[gi] && is_a && !indep_mode)
          begin
            a_seen[gi] <= 1'b1;
            a_pos      <= wr_ptr;
          end
        end
      end

      // Pointer jumps past the /A/ only while searching
      always_ff @(posedge clk) begin
        if (rst)
          rd_ptr <= '0;
        else if (realign)
          rd_ptr <= wrap_inc(a_pos);
        else if (rd_step)
          rd_ptr <= wrap_inc(rd_ptr);
      end

      assign rd_word[gi] = mem[rd_ptr];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Column alignment machine
  // ----------------------------------------------------------------
  logic [3:0] rd_is_a;
  logic       col_any_a;
  logic       col_full_a;
  logic       col_aligned;

  always_comb begin
    for (int i = 0; i < xldm_pkg::NUM_LANES; i++)
      rd_is_a[i] = rd_word[i].ctrl
                   && rd_word[i].data == xldm_pkg::CODE_ALIGN;
  end

  assign col_any_a  = |rd_is_a;
  assign col_full_a = &rd_is_a;

  always_ff @(posedge clk) begin
    if (rst)
      col_state <= xldm_pkg::column_search_state;
    else if (!(&lock_s))
      col_state <= xldm_pkg::column_search_state;
    else if (realign)
      col_state <= xldm_pkg::column_confirm_one;
    else if (rd_step && col_any_a)
    begin
      unique case (col_state)
        xldm_pkg::column_search_state:
          col_state <= xldm_pkg::column_search_state;
        xldm_pkg::column_confirm_one:
          col_state <= col_full_a ? xldm_pkg::column_confirm_two
                                  : xldm_pkg::column_search_state;
        xldm_pkg::column_confirm_two:
          col_state <= col_full_a ? xldm_pkg::column_confirm_three
                                  : xldm_pkg::column_search_state;
        xldm_pkg::column_confirm_three:
          col_state <= col_full_a ? xldm_pkg::column_aligned
                                  : xldm_pkg::column_search_state;
        xldm_pkg::column_aligned:
          col_state <= col_full_a ? xldm_pkg::column_aligned
                                  : xldm_pkg::column_miss_one;
        xldm_pkg::column_miss_one:
          col_state <= col_full_a ? xldm_pkg::column_aligned
                                  : xldm_pkg::column_miss_two;
        xldm_pkg::column_miss_two:
          col_state <= col_full_a ? xldm_pkg::column_aligned
                                  : xldm_pkg::column_miss_three;
        xldm_pkg::column_miss_three:
          col_state <= col_full_a ? xldm_pkg::column_aligned
                                  : xldm_pkg::column_search_state;
      endcase
    end
  end

  assign col_aligned = col_state == xldm_pkg::column_aligned
                       || col_state == xldm_pkg::column_miss_one
                       || col_state == xldm_pkg::column_miss_two
                       || col_state == xldm_pkg::column_miss_three;

  // ----------------------------------------------------------------
  // Receive parallel output
  // ----------------------------------------------------------------
  xldm_pkg::xldm_column_t local_fault;

  always_comb begin
    local_fault[0] = '{err: 1'b1, ctrl: 1'b1, data: xldm_pkg::CODE_SEQ};
    local_fault[1] = '{err: 1'b0, ctrl: 1'b0, data: xldm_pkg::FAULT_ZERO};
    local_fault[2] = '{err: 1'b0, ctrl: 1'b0, data: xldm_pkg::FAULT_ZERO};
    local_fault[3] = '{err: 1'b0, ctrl: 1'b0,
                       data: xldm_pkg::FAULT_LOCAL};
  end

  always_ff @(posedge clk) begin
    if (rst)
    begin
      rx_col       <= '0;
      rx_col_valid <= 4'h0;
    end
    else if (indep_mode)
    begin
      for (int i = 0; i < xldm_pkg::NUM_LANES; i++)
        if (lane_edge[i])
          rx_col[i] <= rxd_s[i];
      rx_col_valid <= lane_edge;
    end
    else
    begin
      if (rx_lane_a_clock)
        rx_col <= col_aligned ? rd_word : local_fault;
      rx_col_valid <= {4{rx_lane_a_clock}};
    end
  end

  // ----------------------------------------------------------------
  // Transmit gap management
  // ----------------------------------------------------------------
  xldm_pkg::xldm_gap_e    gap_state, next_gap_state;
  logic                   gap_start_selector, next_gap_start_selector;
  logic [4:0]             spacing, next_spacing;
  logic [15:0]            lfsr;
  logic                   sync_or_skip_selector;
  xldm_pkg::xldm_column_t next_tx_col;

  assign sync_or_skip_selector = lfsr[0];

  function automatic xldm_pkg::xldm_column_t fill_col(
    input logic [7:0] code
  );
    for (int i = 0; i < xldm_pkg::NUM_LANES; i++)
      fill_col[i] = '{err: 1'b0, ctrl: 1'b1, data: code};
  endfunction : fill_col

  always_comb begin
    logic all_idle;
    logic after_term;
    all_idle   = 1'b1;
    after_term = 1'b0;
    next_tx_col             = txd_s;
    next_gap_state          = xldm_pkg::gap_send_data;
    next_gap_start_selector = gap_start_selector;
    next_spacing            = spacing;
    for (int i = 0; i < xldm_pkg::NUM_LANES; i++)
      if (!(txd_s[i].ctrl && txd_s[i].data == xldm_pkg::CODE_IDLE))
        all_idle = 1'b0;
    if (!xgxs_en)
      next_tx_col = txd_s;
    else if (!all_idle)
    begin
      // Idles in the lanes after the terminate code become /K/
      for (int i = 0; i < xldm_pkg::NUM_LANES; i++)
      begin
        if (after_term && txd_s[i].ctrl
            && txd_s[i].data == xldm_pkg::CODE_IDLE)
          next_tx_col[i].data = xldm_pkg::CODE_SYNC;
        if (txd_s[i].ctrl && txd_s[i].data == xldm_pkg::CODE_TERM)
          after_term = 1'b1;
      end
      next_gap_state = xldm_pkg::gap_send_data;
    end
    else
    begin
      next_gap_state = xldm_pkg::gap_send_fill;
      if (gap_state == xldm_pkg::gap_send_data)
      begin
        if (gap_start_selector)
        begin
          next_tx_col             = fill_col(xldm_pkg::CODE_ALIGN);
          next_gap_start_selector = 1'b0;
          next_spacing            = {1'b1, lfsr[4:1]};
        end
        else
        begin
          next_tx_col             = fill_col(xldm_pkg::CODE_SYNC);
          next_gap_start_selector = 1'b1;
          if (spacing != 5'h00)
            next_spacing = spacing - 5'h01;
        end
      end
      else if (spacing == 5'h00)
      begin
        next_tx_col  = fill_col(xldm_pkg::CODE_ALIGN);
        next_spacing = {1'b1, lfsr[4:1]};
      end
      else
      begin
        next_tx_col  = fill_col(sync_or_skip_selector
                                ? xldm_pkg::CODE_SKIP
                                : xldm_pkg::CODE_SYNC);
        next_spacing = spacing - 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
    begin
      gap_state          <= xldm_pkg::gap_send_data;
      gap_start_selector <= 1'b0;
      spacing            <= xldm_pkg::SPACING_RESET;
      lfsr               <= xldm_pkg::LFSR_SEED;
      tx_col             <= '0;
      tx_col_valid       <= 1'b0;
    end
    else
    begin
      tx_col_valid <= tx_edge;
      if (tx_edge)
      begin
        gap_state          <= next_gap_state;
        gap_start_selector <= next_gap_start_selector;
        spacing            <= next_spacing;
        lfsr   <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        tx_col <= next_tx_col;
      end
    end
  end

  // ----------------------------------------------------------------
  // Realignment indication and register reads
  // ----------------------------------------------------------------
  logic realign_flag;

  always_ff @(posedge clk) begin
    if (rst)
      realign_flag <= 1'b0;
    else if (realign)
      realign_flag <= 1'b1;
    else if (reg_wr && reg_addr == xldm_pkg::REG_REALIGN
             && reg_wdata[xldm_pkg::REALIGN_BIT])
      realign_flag <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      reg_rdata <= 32'h0;
      unique case (reg_addr)
        xldm_pkg::REG_CTRL:
          reg_rdata[1:0] <= ctrl;
        xldm_pkg::REG_STATUS:
        begin
          reg_rdata[3:0] <= lock_s;
          reg_rdata[xldm_pkg::STAT_ALIGN_BIT] <= col_aligned;
        end
        xldm_pkg::REG_REALIGN:
          reg_rdata[xldm_pkg::REALIGN_BIT] <= realign_flag;
        default:
          reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

endmodule : xldm_lane_deskew

`default_nettype wire

/* File: bench/xldm_mac_model.sv */
// Transmit-side protocol device model driving one column per tx_clk pulse
`timescale 1ns/1ns
`default_nettype none

module xldm_mac_model (
  // System clock used to pace the frames
  input  wire logic                    clk,
  // Transmit column toward the block
  output var  logic                    tx_clk,
  output var  xldm_pkg::xldm_column_t  tx_data
);

  initial
  begin
    tx_clk  = 1'b0;
    tx_data = '0;
  end

  // ------------------------------------------------------------
  // One column: setup, rise, hold, then clock stands still
  // ------------------------------------------------------------
  task automatic send(input xldm_pkg::xldm_column_t c);
    @(posedge clk);
    tx_data <= c;
    repeat (3) @(posedge clk);
    tx_clk <= 1'b1;
    repeat (4) @(posedge clk);
    tx_clk  <= 1'b0;
    tx_data <= ~c;
  endtask : send

endmodule : xldm_mac_model
`default_nettype wire

/* File: bench/xldm_lane_deskew_asserts.sv */
// Port checker for the lane deskew and gap manager
`timescale 1ns/1ns
`default_nettype none

module xldm_lane_deskew_asserts #(
  parameter int FIFO_DEPTH = 11
) (
  // Clock, reset and register port
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [xldm_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [31:0]                  reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [31:0]                  reg_rdata,
  // Receive side
  input wire logic [3:0]                   rx_lane_clk,
  input wire xldm_pkg::xldm_column_t       rx_lane_in,
  input wire logic [3:0]                   lane_locked,
  input wire xldm_pkg::xldm_column_t       rx_col,
  input wire logic [3:0]                   rx_col_valid,
  // Transmit side
  input wire logic                         tx_lane_a_clock,
  input wire xldm_pkg::xldm_column_t       tx_lane_data,
  input wire xldm_pkg::xldm_column_t       tx_col,
  input wire logic                         tx_col_valid
);

  localparam logic [39:0] FAULT = {10'h001, 10'h000, 10'h000, 10'h39C};
  logic       indep;
  logic       xgxs;
  logic [2:0] ulk;

  // ------------------------------------------------------------
  // Mode and lock tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk)
    if (rst)
      indep <= 1'b0;
    else if (reg_wr && reg_addr == xldm_pkg::REG_CTRL)
      indep <= reg_wdata[xldm_pkg::CTRL_INDEP_BIT];

  always_ff @(posedge clk)
    if (rst)
      xgxs <= 1'b1;
    else if (reg_wr && reg_addr == xldm_pkg::REG_CTRL)
      xgxs <= reg_wdata[xldm_pkg::CTRL_XGXS_BIT];

  always_ff @(posedge clk)
    if (rst || lane_locked == 4'hF)
      ulk <= 3'h0;
    else if (ulk != 3'h7)
      ulk <= ulk + 3'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_tx_edge; $rose(tx_lane_a_clock); endsequence
  sequence s_tx_out; ##[1:6] tx_col_valid; endsequence

  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_stat;
    reg_rd && reg_addr == xldm_pkg::REG_STATUS |=>
      reg_rdata[31:13] == 19'h0 && reg_rdata[11:4] == 8'h0;
  endproperty
  property p_fault;
    rx_col_valid[0] && !indep && ulk == 3'h7 |-> rx_col == FAULT;
  endproperty
  property p_rx_resp;
    $rose(rx_lane_clk[0]) && !indep |-> ##[1:6] rx_col_valid == 4'hF;
  endproperty
  property p_rx_pulse; rx_col_valid[0] |=> !rx_col_valid[0] [*6]; endproperty
  property p_tx_resp; s_tx_edge |-> s_tx_out; endproperty
  property p_tx_no_idle;
    tx_col_valid && xgxs |-> tx_col[0][8:0] != 9'h107 &&
      tx_col[1][8:0] != 9'h107 && tx_col[2][8:0] != 9'h107 &&
      tx_col[3][8:0] != 9'h107;
  endproperty
  property p_tx_whole;
    tx_col_valid && xgxs && tx_col[0] inside {10'h17C, 10'h1BC, 10'h11C}
      |-> tx_col == {4{tx_col[0]}};
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  a_stat: assert property (p_stat)
    else $error("status spare bits set");
  a_fault: assert property (p_fault)
    else $error("no local fault while unlocked");
  a_rx_resp: assert property (p_rx_resp)
    else $error("no column after lane A edge");
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive valid too long");
  a_tx_resp: assert property (p_tx_resp)
    else $error("no transmit column after edge");
  a_tx_no_idle: assert property (p_tx_no_idle)
    else $error("idle left in transmit column");
  a_tx_whole: assert property (p_tx_whole)
    else $error("fill column not whole");

endmodule : xldm_lane_deskew_asserts

bind xldm_lane_deskew xldm_lane_deskew_asserts #(
  .FIFO_DEPTH(FIFO_DEPTH)
) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_lane_clk(rx_lane_clk), .rx_lane_in(rx_lane_in),
  .lane_locked(lane_locked), .rx_col(rx_col), .rx_col_valid(rx_col_valid),
  .tx_lane_a_clock(tx_lane_a_clock), .tx_lane_data(tx_lane_data),
  .tx_col(tx_col), .tx_col_valid(tx_col_valid)
);
`default_nettype wire

/* File: bench/xldm_lane_deskew_tb_top.sv */
// Self-checking bench for the lane deskew and gap manager
`timescale 1ns/1ns
`default_nettype none

module xldm_lane_deskew_tb_top;
  localparam logic [7:0]  CT = xldm_pkg::REG_CTRL;
  localparam logic [7:0]  ST = xldm_pkg::REG_STATUS;
  localparam logic [7:0]  RA = xldm_pkg::REG_REALIGN;
  localparam logic [39:0] AC = {4{10'h17C}};
  localparam logic [39:0] KC = {4{10'h1BC}};
  localparam logic [39:0] IC = {4{10'h107}};
  localparam logic [39:0] DC = {10'h044, 10'h033, 10'h022, 10'h011};
  localparam logic [39:0] PC = {10'h044, 10'h17C, 10'h17C, 10'h17C};
  localparam logic [39:0] FC = {10'h001, 10'h000, 10'h000, 10'h39C};
  localparam logic [39:0] TC = {10'h107, 10'h107, 10'h1FD, 10'h011};
  localparam logic [39:0] TK = {10'h1BC, 10'h1BC, 10'h1FD, 10'h011};
  localparam logic [39:0] TE = {10'h1FD, 10'h033, 10'h022, 10'h011};
  localparam logic [39:0] QC = {10'h055, 10'h066, 10'h077, 10'h19C};

  logic                   clk;
  logic                   rst;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [31:0]            reg_rdata;
  logic [3:0]             rx_ck;
  logic [3:0]             lane_locked;
  logic [3:0]             rx_col_valid;
  logic                   tx_ck;
  logic                   tx_col_valid;
  xldm_pkg::xldm_column_t rx_in;
  xldm_pkg::xldm_column_t rx_col;
  xldm_pkg::xldm_column_t tx_in;
  xldm_pkg::xldm_column_t tx_col;
  xldm_pkg::xldm_column_t txs;
  int                     num_errors;
  int                     n_tests;

  xldm_lane_deskew u_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_lane_clk(rx_ck), .rx_lane_in(rx_in), .lane_locked(lane_locked),
    .rx_col(rx_col), .rx_col_valid(rx_col_valid),
    .tx_lane_a_clock(tx_ck), .tx_lane_data(tx_in),
    .tx_col(tx_col), .tx_col_valid(tx_col_valid)
  );

  xldm_mac_model u_mac (.clk(clk), .tx_clk(tx_ck), .tx_data(tx_in));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Access and comparison tasks
  // ------------------------------------------------------------
  task automatic summarize;
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [39:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask : rd

  // Lane clocks stand still between columns, data inverted meanwhile
  task automatic push(input logic [39:0] c, input int n);
    repeat (n)
    begin
      @(posedge clk);
      rx_in <= c;
      repeat (3) @(posedge clk);
      rx_ck <= 4'hF;
      repeat (4) @(posedge clk);
      rx_ck <= 4'h0;
      rx_in <= ~c;
    end
  endtask : push

  task automatic tx(input logic [39:0] c);
    int k;
    k = 0;
    fork
      u_mac.send(c);
      do
      begin
        @(posedge clk);
        #1;
        k++;
      end
      while (tx_col_valid !== 1'b1 && k < 20);
    join
    txs = tx_col;
    // Valid is a one-cycle pulse; the loop bound tells a timeout apart
    if (k >= 20)
    begin
      num_errors++;
      summarize();
    end
  endtask : tx

  function automatic logic [39:0] kr(input xldm_pkg::xldm_column_t c);
    return {39'h0, c == {4{c[0]}} && c[0] inside {10'h1BC, 10'h11C}};
  endfunction : kr

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst         = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    rx_ck       = 4'h0;
    rx_in       = '0;
    lane_locked = 4'hF;
    num_errors  = 0;
    n_tests     = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Lock pins need their synchroniser depth before the first status read
    repeat (3) @(posedge clk);
    rd(ST, 32'h0000000F, "status");
    rd(CT, 32'h00000002, "ctrl");
    rd(RA, 32'h0, "realign");
    rd(8'h0C, 32'h0, "unmapped");
    push(DC, 1);
    rd(ST, 32'h0000000F, "status search");
    check("rx fault", rx_col, FC);
    push(AC, 1);
    push(DC, 12);
    rd(ST, 32'h0000000F, "status confirm");
    rd(RA, 32'h00000010, "realign set");
    check("rx fault confirm", rx_col, FC);
    wr(RA, 32'h00000010);
    rd(RA, 32'h0, "realign clear");
    push(AC, 3);
    push(DC, 12);
    rd(ST, 32'h0000100F, "status aligned");
    rd(RA, 32'h0, "no realign");
    check("rx data", rx_col, DC);
    lane_locked <= 4'h7;
    push(DC, 1);
    rd(ST, 32'h00000007, "status unlock");
    check("rx fault unlock", rx_col, FC);
    lane_locked <= 4'hF;
    push(AC, 4);
    push(DC, 12);
    rd(ST, 32'h0000100F, "status realigned");
    push(PC, 1);
    push(DC, 12);
    rd(ST, 32'h0000100F, "status miss");
    push(PC, 3);
    push(DC, 12);
    rd(ST, 32'h0000000F, "status lost");
    wr(CT, 32'h00000003);
    push(DC, 1);
    rd(CT, 32'h00000003, "ctrl indep");
    check("rx indep", rx_col, DC);
    tx(DC);
    check("tx data", txs, DC);
    tx(TC);
    check("tx term", txs, TK);
    tx(IC);
    check("tx open k", txs, KC);
    repeat (15)
    begin
      tx(IC);
      check("tx fill", kr(txs), 40'h1);
    end
    tx(IC);
    check("tx align", txs, AC);
    tx(QC);
    check("tx status msg", txs, QC);
    tx(TE);
    check("tx term d", txs, TE);
    tx(IC);
    check("tx open a", txs, AC);
    wr(CT, 32'h0);
    tx(IC);
    check("tx pass", txs, IC);
    summarize();
  end

endmodule : xldm_lane_deskew_tb_top
`default_nettype wire
